// ==== hw/ppcr_pkg.sv ====
// Constants, register map and carrier types of the crossing reporter.
package ppcr_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  localparam int AW = 4;
  localparam int DW = 32;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_NODE = 4'h1;
  localparam logic [3:0] REG_ID_PULSE = 4'h2;
  localparam logic [3:0] REG_ID_STAT = 4'h3;
  localparam logic [3:0] REG_ID_LVL = 4'h4;
  localparam logic [3:0] REG_ID_PROG = 4'h5;
  localparam logic [3:0] REG_PULSE_MS = 4'h6;
  localparam logic [3:0] REG_UPD_MS = 4'h7;
  localparam logic [3:0] REG_HB_MS = 4'h8;
  localparam logic [3:0] REG_BITTIME = 4'h9;
  localparam logic [3:0] REG_STAT = 4'ha;
  localparam logic [3:0] REG_CNT = 4'hb;
  localparam logic [3:0] REG_CODE = 4'hc;
  localparam logic [3:0] REG_PROG = 4'hd;

  localparam int CTRL_EXT = 0;
  localparam int CTRL_COPEN = 1;
  localparam int CTRL_CONT = 2;

  localparam int ST1_ERR_TIME = 0;
  localparam int ST1_ERR_CRC = 1;
  localparam int ST1_ERR_USB = 2;
  localparam int ST1_ERR_PARAM = 5;
  localparam int ST1_RW = 8;
  localparam int ST1_RANGE = 9;
  localparam int ST1_READ = 10;
  localparam int ST1_NEG = 11;
  localparam int ST1_PULSE = 12;
  localparam int ST2_SUM = 1;
  localparam int ST2_DIFF = 2;

  localparam logic [10:0] COB_STAT = 11'h180;
  localparam logic [10:0] COB_PROG = 11'h200;
  localparam logic [10:0] COB_LVL = 11'h280;
  localparam logic [10:0] COB_HB = 11'h700;
  localparam logic [7:0] HB_OPERATIONAL = 8'h05;

  localparam logic [3:0] LEN_PULSE = 4'h0;
  localparam logic [3:0] LEN_HB = 4'h1;
  localparam logic [3:0] LEN_PROG = 4'h4;
  localparam logic [3:0] LEN_STAT = 4'h7;
  localparam logic [3:0] LEN_LVL = 4'h8;

  localparam logic [6:0] NODE_MIN = 7'h01;
  localparam logic [6:0] NODE_MAX = 7'h7f;
  localparam logic [2:0] RST_CTRL = 3'h4;
  localparam logic [6:0] RST_NODE = 7'h01;
  localparam logic [15:0] RST_PULSE_MS = 16'h0032;
  localparam logic [15:0] RST_UPD_MS = 16'h000a;
  localparam logic [15:0] RST_HB_MS = 16'h0000;
  localparam logic [28:0] RST_ID = 29'h0;
  localparam logic [31:0] RST_BITTIME = 32'h0;

  typedef enum logic [1:0] {PP_IDLE, PP_ARMED, PP_PULSE, PP_WAIT} ppcr_pp_t;
  typedef enum logic [1:0] {K_PULSE, K_STAT, K_LVL, K_HB} ppcr_kind_t;

  typedef struct packed {
    logic ext;
    logic [28:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } ppcr_frame_t;

  typedef struct packed {
    logic inRange;
    logic codeOk;
    logic centerCross;
    logic readOk;
    logic sumFault;
    logic diffFault;
    logic sumValid;
    logic diffValid;
    logic rwCap;
    logic errTime;
    logic errCrc;
    logic errUsb;
    logic errParam;
    logic [31:0] code;
    logic [15:0] sumLevel;
    logic [15:0] diffLevel;
  } ppcr_sense_t;
endpackage

// ==== hw/ppcr_tick_div.sv ====
// Divider that makes a one-cycle millisecond enable pulse.
`timescale 1ns/1ns
module ppcr_tick_div
  import ppcr_pkg::*;
#(
  parameter int DIV = MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } ppcr_div_t;

  ppcr_div_t st_q;
  ppcr_div_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == CW'(DIV - 1)) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule

// ==== hw/ppcr_reporter.sv ====
// Positioning pulse generator and CAN message framer of a reading antenna.
// Summary of operation
// RULE1: Pulse is armed only after a code was decoded in this crossing.
// RULE2: At most one pulse is produced per crossing.
// RULE3: A new pulse needs the transponder to leave the range first.
// RULE4: Pulse starts at antenna center and lasts the configured milliseconds.
// RULE5: Status one low byte: time, CRC, USB and parameter errors.
// RULE6: Status one bits 8 to 10: writable, in range, code readable.
// RULE7: Status one bit 11 negative difference, bit 12 pulse active.
// RULE8: Status two bits 1 and 2: code decodable on sum, difference.
// RULE9: Standard or extended identifiers for send and receive; ids, timing set.
// RULE10: Three transmit objects and one receive object.
// RULE11: Send at update rate always, or only while transponder present.
// RULE12: An object with identifier zero is disabled.
// RULE13: Receive object carries four bytes of new code, low byte first.
// RULE14: Each pulse sends the first transmit object with no data.
// RULE15: Second object: status word, code, readings count; seven bytes.
// RULE16: Third object bytes 1 to 4: sum and difference levels.
// RULE17: Third object bytes 5 to 8: three counters and status two.
// RULE18: Network mode ids come from a node address of 1 to 127; here the pulse id stays the configured one.
// RULE19: The network must keep every identifier unique.
// RULE20: Network mode status message uses 0x180 plus node.
// RULE21: Network mode level message uses 0x280 plus node.
// RULE22: Nonzero heartbeat time sends state on 0x700 plus node; here sent in network mode only.
// RULE23: Counters wrap at 255; readings count clears on a new crossing.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module ppcr_reporter
  import ppcr_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [AW-1:0] regAddr,
  input wire logic [DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DW-1:0] regRdata,
  input wire ppcr_sense_t sense,
  output logic posPulse,
  output logic txValid,
  input wire logic txReady,
  output ppcr_frame_t txFrame,
  input wire logic rxValid,
  input wire ppcr_frame_t rxFrame,
  output logic progValid,
  output logic [31:0] progCode,
  output logic [31:0] bitTiming
);
  typedef struct packed {
    ppcr_pp_t ppState;
    logic pulse;
    logic [15:0] pulseLeft;
    logic prevRange;
    logic [31:0] codeQ;
    logic [7:0] readCnt;
    logic [7:0] validCnt;
    logic [7:0] sumFaultCnt;
    logic [7:0] diffFaultCnt;
    logic [15:0] updLeft;
    logic [15:0] hbLeft;
    logic pendPulse;
    logic pendStat;
    logic pendLvl;
    logic pendHb;
    logic txValid;
    ppcr_kind_t txKind;
    ppcr_frame_t txFrame;
    logic progValid;
    logic [31:0] progCode;
    logic [31:0] rdata;
    logic [2:0] ctrl;
    logic [6:0] node;
    logic [28:0] idPulse;
    logic [28:0] idStat;
    logic [28:0] idLvl;
    logic [28:0] idProg;
    logic [15:0] pulseMs;
    logic [15:0] updMs;
    logic [15:0] hbMs;
    logic [31:0] bitTime;
  } ppcr_state_t;

  ppcr_state_t st_q;
  ppcr_state_t st_d;
  logic tick;
  logic copen;
  logic effExt;
  logic rise;
  logic [10:0] nodeW;
  logic [28:0] effStat;
  logic [28:0] effLvl;
  logic [28:0] effProg;
  logic [28:0] effHb;
  logic [15:0] stat1;
  logic [7:0] stat2;

  ppcr_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick)
  );

  // In network mode the status, level and receive identifiers follow the node address
  // (the pulse identifier does not) and frames are always standard, so the extended
  // select only matters in basic mode.
  always_comb begin
    copen = st_q.ctrl[CTRL_COPEN];
    effExt = st_q.ctrl[CTRL_EXT] & ~copen; // [RULE9]
    nodeW = {4'h0, st_q.node};
    effStat = copen ? {18'h0, COB_STAT + nodeW} : st_q.idStat; // [RULE20]
    effLvl = copen ? {18'h0, COB_LVL + nodeW} : st_q.idLvl; // [RULE21]
    effProg = copen ? {18'h0, COB_PROG + nodeW} : st_q.idProg; // [RULE18]
    effHb = {18'h0, COB_HB + nodeW}; // [RULE22]
    rise = sense.inRange & ~st_q.prevRange;
  end

  always_comb begin
    stat1 = 16'h0;
    stat1[ST1_ERR_TIME] = sense.errTime; // [RULE5]
    stat1[ST1_ERR_CRC] = sense.errCrc; // [RULE5]
    stat1[ST1_ERR_USB] = sense.errUsb; // [RULE5]
    stat1[ST1_ERR_PARAM] = sense.errParam; // [RULE5]
    stat1[ST1_RW] = sense.rwCap; // [RULE6]
    stat1[ST1_RANGE] = sense.inRange; // [RULE6]
    stat1[ST1_READ] = sense.codeOk; // [RULE6]
    stat1[ST1_NEG] = sense.diffLevel[15]; // [RULE7]
    stat1[ST1_PULSE] = st_q.pulse; // [RULE7]
    stat2 = 8'h0;
    stat2[ST2_SUM] = sense.sumValid; // [RULE8]
    stat2[ST2_DIFF] = sense.diffValid; // [RULE8]
  end

  always_comb begin
    st_d = st_q;
    st_d.progValid = 1'b0;
    st_d.rdata = '0;
    st_d.prevRange = sense.inRange;

    // Transmit slot: the arbiter clears pending bits before events set
    // them below, so an event in the same cycle is never lost.
    if (!st_q.txValid || txReady) begin
      st_d.txValid = 1'b0;
      if (st_q.pendPulse) begin
        st_d.pendPulse = 1'b0;
        st_d.txValid = 1'b1;
        st_d.txKind = K_PULSE;
        st_d.txFrame = '{effExt, st_q.idPulse, LEN_PULSE, 64'h0}; // [RULE14]
      end else if (st_q.pendHb) begin
        st_d.pendHb = 1'b0;
        st_d.txValid = 1'b1;
        st_d.txKind = K_HB;
        st_d.txFrame = '{1'b0, effHb, LEN_HB,
                         {56'h0, HB_OPERATIONAL}}; // [RULE22]
      end else if (st_q.pendStat) begin
        st_d.pendStat = 1'b0;
        st_d.txValid = 1'b1;
        st_d.txKind = K_STAT;
        st_d.txFrame = '{effExt, effStat, LEN_STAT,
                         {8'h00, st_q.readCnt, st_q.codeQ, stat1}}; // [RULE15]
      end else if (st_q.pendLvl) begin
        st_d.pendLvl = 1'b0;
        st_d.txValid = 1'b1;
        st_d.txKind = K_LVL;
        st_d.txFrame = '{effExt, effLvl, LEN_LVL,
                         {stat2, st_q.diffFaultCnt, st_q.sumFaultCnt,
                          st_q.validCnt, sense.diffLevel,
                          sense.sumLevel}}; // [RULE16] [RULE17]
      end
    end

    if (rise) begin
      st_d.readCnt = 8'h00; // [RULE23]
    end
    if (sense.readOk) begin
      st_d.codeQ = sense.code;
      st_d.readCnt = st_d.readCnt + 8'h01; // [RULE23]
      st_d.validCnt = st_q.validCnt + 8'h01; // [RULE23]
    end
    if (sense.sumFault) begin
      st_d.sumFaultCnt = st_q.sumFaultCnt + 8'h01;
    end
    if (sense.diffFault) begin
      st_d.diffFaultCnt = st_q.diffFaultCnt + 8'h01;
    end

    unique case (st_q.ppState)
      PP_IDLE: begin
        if (sense.inRange && (sense.codeOk || sense.readOk)) begin
          st_d.ppState = PP_ARMED; // [RULE1]
        end
      end
      PP_ARMED: begin
        if (!sense.inRange) begin
          st_d.ppState = PP_IDLE;
        end else if (sense.centerCross) begin
          st_d.ppState = PP_PULSE; // [RULE4]
          st_d.pulse = 1'b1;
          st_d.pulseLeft = st_q.pulseMs;
          if (st_q.idPulse != '0) begin
            st_d.pendPulse = 1'b1; // [RULE14] [RULE12]
          end
        end
      end
      PP_PULSE: begin
        // A zero duration still gives a pulse of up to one millisecond.
        if (tick) begin
          if (st_q.pulseLeft <= 16'h0001) begin
            st_d.pulse = 1'b0;
            st_d.ppState = PP_WAIT; // [RULE2]
          end else begin
            st_d.pulseLeft = st_q.pulseLeft - 16'h0001; // [RULE4]
          end
        end
      end
      PP_WAIT: begin
        if (!sense.inRange) begin
          st_d.ppState = PP_IDLE; // [RULE3]
        end
      end
    endcase

    if (tick && st_q.updMs != '0) begin
      if (st_q.updLeft <= 16'h0001) begin
        st_d.updLeft = st_q.updMs;
        if (st_q.ctrl[CTRL_CONT] || sense.inRange) begin // [RULE11]
          st_d.pendStat = st_d.pendStat | (effStat != '0); // [RULE12]
          st_d.pendLvl = st_d.pendLvl | (effLvl != '0); // [RULE12]
        end
      end else begin
        st_d.updLeft = st_q.updLeft - 16'h0001;
      end
    end
    if (tick && copen && st_q.hbMs != '0) begin
      if (st_q.hbLeft <= 16'h0001) begin
        st_d.hbLeft = st_q.hbMs;
        st_d.pendHb = 1'b1; // [RULE22]
      end else begin
        st_d.hbLeft = st_q.hbLeft - 16'h0001;
      end
    end

    if (rxValid && effProg != '0 && rxFrame.ext == effExt &&
        rxFrame.id == effProg && rxFrame.dlc == LEN_PROG) begin // [RULE12]
      st_d.progValid = 1'b1;
      st_d.progCode = rxFrame.data[31:0]; // [RULE13]
    end

    if (regWr) begin
      case (regAddr)
        REG_CTRL: st_d.ctrl = regWdata[2:0];
        REG_NODE: begin
          if (regWdata[6:0] >= NODE_MIN && regWdata[31:7] == '0) begin
            st_d.node = regWdata[6:0]; // [RULE18]
          end
        end
        REG_ID_PULSE: st_d.idPulse = regWdata[28:0];
        REG_ID_STAT: st_d.idStat = regWdata[28:0];
        REG_ID_LVL: st_d.idLvl = regWdata[28:0];
        REG_ID_PROG: st_d.idProg = regWdata[28:0];
        REG_PULSE_MS: st_d.pulseMs = regWdata[15:0];
        REG_UPD_MS: st_d.updMs = regWdata[15:0];
        REG_HB_MS: st_d.hbMs = regWdata[15:0];
        REG_BITTIME: st_d.bitTime = regWdata;
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        REG_CTRL: st_d.rdata = {29'h0, st_q.ctrl};
        REG_NODE: st_d.rdata = {25'h0, st_q.node};
        REG_ID_PULSE: st_d.rdata = {3'h0, st_q.idPulse};
        REG_ID_STAT: st_d.rdata = {3'h0, st_q.idStat};
        REG_ID_LVL: st_d.rdata = {3'h0, st_q.idLvl};
        REG_ID_PROG: st_d.rdata = {3'h0, st_q.idProg};
        REG_PULSE_MS: st_d.rdata = {16'h0, st_q.pulseMs};
        REG_UPD_MS: st_d.rdata = {16'h0, st_q.updMs};
        REG_HB_MS: st_d.rdata = {16'h0, st_q.hbMs};
        REG_BITTIME: st_d.rdata = st_q.bitTime;
        REG_STAT: st_d.rdata = {8'h0, stat2, stat1};
        REG_CNT: st_d.rdata = {st_q.diffFaultCnt, st_q.sumFaultCnt,
                               st_q.validCnt, st_q.readCnt};
        REG_CODE: st_d.rdata = st_q.codeQ;
        REG_PROG: st_d.rdata = st_q.progCode;
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.ctrl <= RST_CTRL;
      st_q.node <= RST_NODE;
      st_q.idPulse <= RST_ID;
      st_q.idStat <= RST_ID;
      st_q.idLvl <= RST_ID;
      st_q.idProg <= RST_ID;
      st_q.pulseMs <= RST_PULSE_MS;
      st_q.updMs <= RST_UPD_MS;
      st_q.hbMs <= RST_HB_MS;
      st_q.bitTime <= RST_BITTIME;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdata = st_q.rdata;
  assign posPulse = st_q.pulse;
  assign txValid = st_q.txValid;
  assign txFrame = st_q.txFrame;
  assign progValid = st_q.progValid;
  assign progCode = st_q.progCode;
  assign bitTiming = st_q.bitTime;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_pulse_after_code;
    $rose(posPulse) |-> $past(st_q.ppState == PP_ARMED && sense.centerCross);
  endproperty
  a_pulse_after_code: assert property (p_pulse_after_code) // [RULE1]
    else $error("pulse rose without an armed crossing");

  property p_one_per_crossing;
    st_q.ppState == PP_WAIT |=> !$rose(posPulse);
  endproperty
  a_one_per_crossing: assert property (p_one_per_crossing) // [RULE2]
    else $error("second pulse in one crossing");

  property p_leave_first;
    st_q.ppState == PP_WAIT && sense.inRange |=> st_q.ppState == PP_WAIT;
  endproperty
  a_leave_first: assert property (p_leave_first) // [RULE3]
    else $error("rearmed while transponder still in range");

  property p_pulse_load;
    $rose(posPulse) |-> st_q.pulseLeft == $past(st_q.pulseMs);
  endproperty
  a_pulse_load: assert property (p_pulse_load) // [RULE4]
    else $error("pulse duration not loaded");

  property p_pulse_frame;
    txValid && st_q.txKind == K_PULSE |-> txFrame.dlc == LEN_PULSE;
  endproperty
  a_pulse_frame: assert property (p_pulse_frame) // [RULE14]
    else $error("pulse frame carries data");

  property p_stat_frame;
    txValid && st_q.txKind == K_STAT |->
      txFrame.dlc == LEN_STAT && txFrame.data[63:56] == 8'h00;
  endproperty
  a_stat_frame: assert property (p_stat_frame) // [RULE15]
    else $error("status frame layout wrong");

  property p_copen_ids;
    $rose(txValid) && $past(copen) && st_q.txKind == K_STAT |->
      txFrame.id == {18'h0, COB_STAT + $past(nodeW)};
  endproperty
  a_copen_ids: assert property (p_copen_ids) // [RULE20]
    else $error("status frame id not base plus node");

  property p_no_zero_id;
    txValid |-> txFrame.id != '0;
  endproperty
  a_no_zero_id: assert property (p_no_zero_id) // [RULE12]
    else $error("frame sent on disabled object");

  property p_prog_take;
    progValid |-> $past(rxValid && rxFrame.dlc == LEN_PROG) &&
      progCode == $past(rxFrame.data[31:0]);
  endproperty
  a_prog_take: assert property (p_prog_take) // [RULE13]
    else $error("programming code not taken from receive frame");

  property p_node_range;
    st_q.node >= NODE_MIN && st_q.node <= NODE_MAX;
  endproperty
  a_node_range: assert property (p_node_range) // [RULE18]
    else $error("node address out of range");

  property p_crossing_clear;
    $rose(sense.inRange) |=> st_q.readCnt <= 8'h01;
  endproperty
  a_crossing_clear: assert property (p_crossing_clear) // [RULE23]
    else $error("readings count not cleared on new crossing");

  property p_tx_hold;
    txValid && !txReady |=> txValid && $stable(txFrame);
  endproperty
  a_tx_hold: assert property (p_tx_hold) // [RULE10]
    else $error("frame changed while not accepted");

  c_pulse: cover property ($rose(posPulse) ##[1:1000] $fell(posPulse));
  c_lvl: cover property (txValid && txReady && st_q.txKind == K_LVL);
  c_prog: cover property (progValid);
  c_hb: cover property (txValid && st_q.txKind == K_HB);
endmodule

// ==== sim/ppcr_can_peer.sv ====
// Model of the CAN controller that takes frames and delivers receptions.
`timescale 1ns/1ns
module ppcr_can_peer
  import ppcr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic txValid,
  input wire ppcr_frame_t txFrame,
  output logic txReady,
  output logic accStb,
  output ppcr_frame_t accFrame,
  input wire logic rxGo,
  input wire ppcr_frame_t rxReq,
  output logic rxValid,
  output ppcr_frame_t rxFrame
);
  logic [2:0] stallCnt;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stallCnt <= 3'h0;
      txReady <= 1'b0;
      accStb <= 1'b0;
      rxValid <= 1'b0;
      rxFrame <= '0;
    end else begin
      // A slow bus grants one slot in eight, so frames must wait.
      stallCnt <= stallCnt + 3'h1;
      txReady <= !slow || stallCnt == 3'h5;
      accStb <= txValid && txReady;
      if (txValid && txReady) accFrame <= txFrame;
      rxValid <= rxGo;
      // Idle receive lines change every cycle so stale data cannot match.
      rxFrame <= rxGo ? rxReq : ~rxFrame;
    end
  end
endmodule

// ==== sim/ppcr_reporter_tb.sv ====
// Self-checking bench of the crossing reporter against a reference model.
`timescale 1ns/1ns
module ppcr_reporter_tb
  import ppcr_pkg::*;
;
  localparam int TK = 10;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] regAddr = '0;
  logic [DW-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DW-1:0] regRdata;
  ppcr_sense_t sense = '0;
  logic posPulse, txValid, txReady, rxValid, progValid, accStb, inPrev;
  ppcr_frame_t txFrame, rxFrame, accFrame, ef;
  ppcr_frame_t rxReq = '0;
  logic [31:0] progCode, bitTiming, codeQ, expCode;
  logic slow = 1'b0;
  logic rxGo = 1'b0;
  logic chk = 1'b0;
  logic progExp = 1'b0;
  logic [7:0] readCnt, validCnt, sumF, diffF;
  integer failures = 0, compares = 0, seed = 4, cyc = 0, kd, k;
  integer kindCnt [5] = '{default: 0};
  logic [31:0] regM [16] = '{default: 32'h0};

  initial forever #5 clk_sys = ~clk_sys;

  ppcr_reporter #(.TICK_CYCLES(TK)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sense(sense), .posPulse(posPulse),
    .txValid(txValid), .txReady(txReady), .txFrame(txFrame),
    .rxValid(rxValid), .rxFrame(rxFrame), .progValid(progValid),
    .progCode(progCode), .bitTiming(bitTiming));
  ppcr_can_peer i_peer (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
    .txValid(txValid), .txFrame(txFrame), .txReady(txReady),
    .accStb(accStb), .accFrame(accFrame), .rxGo(rxGo), .rxReq(rxReq),
    .rxValid(rxValid), .rxFrame(rxFrame));

  task automatic check(input string what, input logic [97:0] seen,
                       input logic [97:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] msk(input int a);
    case (a)
      0: msk = 32'h7;
      1: msk = 32'h7f;
      2, 3, 4, 5: msk = 32'h1fffffff;
      6, 7, 8: msk = 32'hffff;
      9: msk = 32'hffffffff;
      default: msk = 32'h0;
    endcase
  endfunction

  function automatic logic [15:0] stat1();
    // Pulse bit stays zero: frame data is judged only outside pulses.
    return {4'h0, sense.diffLevel[15], sense.codeOk, sense.inRange,
      sense.rwCap, 2'h0, sense.errParam, 2'h0, sense.errUsb, sense.errCrc,
      sense.errTime};
  endfunction

  function automatic ppcr_frame_t expf(input ppcr_frame_t f, output int kk);
    logic cop;
    logic [28:0] nd;
    cop = regM[0][CTRL_COPEN];
    nd = {22'h0, regM[1][6:0]};
    expf = ~f;
    kk = 4;
    expf.ext = regM[0][CTRL_EXT] && !cop;
    if (f.id == regM[2][28:0] && f.id != 0) begin
      kk = 0;
      expf = '{expf.ext, f.id, LEN_PULSE, 64'h0};
    end else if (cop && regM[8] != 0 && f.id == 29'h700 + nd) begin
      kk = 3;
      expf = '{1'b0, f.id, LEN_HB, {56'h0, HB_OPERATIONAL}};
    end else if (f.id == (cop ? 29'h180 + nd : regM[3][28:0]) && f.id != 0)
    begin
      kk = 1;
      expf = '{expf.ext, f.id, LEN_STAT, {8'h0, readCnt, codeQ, stat1()}};
    end else if (f.id == (cop ? 29'h280 + nd : regM[4][28:0]) && f.id != 0)
    begin
      kk = 2;
      expf = '{expf.ext, f.id, LEN_LVL, {5'h0, sense.diffValid,
        sense.sumValid, 1'b0, diffF, sumF, validCnt, sense.diffLevel,
        sense.sumLevel}};
    end
  endfunction

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (!rst_n) begin
      {readCnt, validCnt, sumF, diffF, codeQ} <= '0;
    end else begin
      if (sense.inRange && !inPrev) readCnt <= {7'h0, sense.readOk};
      else if (sense.readOk) readCnt <= readCnt + 8'h1;
      if (sense.readOk) validCnt <= validCnt + 8'h1;
      if (sense.readOk) codeQ <= sense.code;
      if (sense.sumFault) sumF <= sumF + 8'h1;
      if (sense.diffFault) diffF <= diffF + 8'h1;
      if (accStb) begin
        ef = expf(accFrame, kd);
        kindCnt[kd] = kindCnt[kd] + 1;
        if (chk || kd == 0) check("frame", accFrame, ef);
      end
      if (progExp) check("prog code", progCode, expCode);
      check("prog valid", progValid, progExp);
    end
    inPrev <= rst_n && sense.inRange;
    progExp <= rst_n && rxValid && rxFrame.dlc == LEN_PROG &&
      rxFrame.ext == (regM[0][CTRL_EXT] && !regM[0][CTRL_COPEN]) &&
      rxFrame.id == (regM[0][CTRL_COPEN] ? 29'h200 + regM[1][6:0] :
      regM[5][28:0]) && rxFrame.id != 0;
    if (rxValid) expCode <= rxFrame.data[31:0];
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    chk <= 1'b0;
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    if (a != REG_NODE || (d >= 1 && d <= 127)) regM[a] = d & msk(a);
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check("read data", regRdata, exp);
    @(posedge clk_sys);
  endtask

  task automatic regs_chk();
    for (int a = 0; a < 16; a++) begin
      if (a < 10 || a > 13) rdchk(a[3:0], regM[a]);
    end
  endtask

  task automatic settle(input logic inR);
    ppcr_sense_t s;
    chk <= 1'b0;
    s = 77'({$random(seed), $random(seed), $random(seed)});
    {s.inRange, s.codeOk} = {2{inR}};
    {s.centerCross, s.readOk, s.sumFault, s.diffFault} = 4'h0;
    sense <= s;
    // Frames loaded before the change must drain before judging data.
    repeat (20) @(posedge clk_sys);
    chk <= 1'b1;
  endtask

  task automatic pulse_try(input logic exp);
    int len;
    len = 0;
    repeat (3) @(posedge clk_sys);
    sense.centerCross <= 1'b1;
    @(posedge clk_sys);
    sense.centerCross <= 1'b0;
    #1;
    check("pulse start", posPulse, exp);
    while (posPulse === 1'b1 && len < 100) begin
      len++;
      @(posedge clk_sys);
      #1;
    end
    if (exp) check("pulse length", len >= 20 && len <= 31, 1'b1);
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic send(input logic e, input logic [28:0] id,
                      input logic [3:0] n, input logic [31:0] c);
    rxReq <= '{e, id, n, {32'h0, c}};
    rxGo <= 1'b1;
    @(posedge clk_sys);
    rxGo <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Frames queued under the old mode would be judged by the new one, so
  // updates stop and the queue drains before the mode changes.
  task automatic set_mode(input logic [31:0] c);
    wr(REG_UPD_MS, 32'h0);
    repeat (40) @(posedge clk_sys);
    wr(REG_CTRL, c);
    wr(REG_UPD_MS, 32'h2);
  endtask

  initial begin
    {regM[0], regM[1], regM[6], regM[7]} = {29'h0, RST_CTRL, 25'h0, RST_NODE,
      16'h0, RST_PULSE_MS, 16'h0, RST_UPD_MS};
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    regs_chk();
    repeat (300) @(posedge clk_sys);
    check("frames with ids off", kindCnt[1] + kindCnt[2] + kindCnt[4], 0);
    wr(REG_ID_PULSE, 32'h11);
    wr(REG_ID_STAT, 32'h22);
    wr(REG_ID_LVL, 32'h33);
    wr(REG_ID_PROG, 32'h44);
    wr(REG_PULSE_MS, 32'h3);
    wr(REG_UPD_MS, 32'h2);
    wr(REG_BITTIME, $random(seed));
    wr(REG_NODE, 32'h0);
    wr(REG_NODE, 32'h80);
    wr(REG_STAT, 32'hffffffff);
    wr(4'he, 32'h5a5a5a5a);
    regs_chk();
    check("bit timing", bitTiming, regM[9]);
    slow <= 1'b1;
    settle(1'b1);
    repeat (400) @(posedge clk_sys);
    check("steady sends", kindCnt[1] > 5 && kindCnt[2] > 5, 1'b1);
    chk <= 1'b0;
    repeat (514) begin
      {sense.readOk, sense.sumFault, sense.diffFault} <= {3{!sense.readOk}};
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rdchk(REG_CNT, {diffF, sumF, validCnt, readCnt});
    rdchk(REG_CODE, codeQ);
    settle(1'b1);
    repeat (100) @(posedge clk_sys);
    chk <= 1'b0;
    sense.inRange <= 1'b0;
    repeat (3) @(posedge clk_sys);
    sense.inRange <= 1'b1;
    pulse_try(1'b1);
    pulse_try(1'b0);
    {sense.inRange, sense.codeOk} <= 2'h0;
    repeat (3) @(posedge clk_sys);
    sense.inRange <= 1'b1;
    pulse_try(1'b0);
    sense.codeOk <= 1'b1;
    pulse_try(1'b1);
    check("pulse frames", kindCnt[0], 2);
    send(1'b0, 29'h44, LEN_PROG, $random(seed));
    send(1'b0, 29'h44, 4'h3, $random(seed));
    send(1'b1, 29'h44, LEN_PROG, $random(seed));
    send(1'b0, 29'h45, LEN_PROG, $random(seed));
    wr(REG_CTRL, 32'h0);
    settle(1'b0);
    k = kindCnt[1];
    repeat (200) @(posedge clk_sys);
    check("sends out of field", kindCnt[1] - k, 0);
    settle(1'b1);
    repeat (200) @(posedge clk_sys);
    check("sends in field", kindCnt[1] - k > 3, 1'b1);
    wr(REG_NODE, 32'h5);
    wr(REG_HB_MS, 32'h3);
    set_mode(32'h6);
    settle(1'b1);
    repeat (300) @(posedge clk_sys);
    check("heartbeats", kindCnt[3] > 3, 1'b1);
    send(1'b0, 29'h205, LEN_PROG, $random(seed));
    // Stop heartbeats just after one went out, so none is left queued.
    k = kindCnt[3];
    wait (kindCnt[3] != k);
    @(posedge clk_sys);
    wr(REG_HB_MS, 32'h0);
    wr(REG_ID_STAT, 32'h1abcde01);
    set_mode(32'h5);
    settle(1'b1);
    repeat (200) @(posedge clk_sys);
    send(1'b1, 29'h44, LEN_PROG, $random(seed));
    rdchk(REG_PROG, rxReq.data[31:0]);
    check("unknown frames", kindCnt[4], 0);
    wrap_up();
  end
endmodule
